// ---- logic/sbt_defs.vh ----
// Constants for the break and synchronous master transmitter: register
// indices, bit positions, reset values and timing counts.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef SBT_DEFS_VH
`define SBT_DEFS_VH

// Register indices on the plain register port
`define SBT_ADDR_RX_CTRL 3'h0
`define SBT_ADDR_TX_BUF 3'h1
`define SBT_ADDR_TX_CTRL 3'h2
`define SBT_ADDR_BAUD_CTRL 3'h3
`define SBT_ADDR_DIV_HIGH 3'h4
`define SBT_ADDR_DIV_LOW 3'h5
`define SBT_ADDR_FLAGS 3'h6

// transmit_status_control bits
`define SBT_TX_MASTER 7
`define SBT_TX_NINTH_EN 6
`define SBT_TX_ENABLE 5
`define SBT_TX_SYNC 4
`define SBT_TX_BREAK 3
`define SBT_TX_HIGH_SPEED 2
`define SBT_TX_SR_EMPTY 1
`define SBT_TX_NINTH_VAL 0

// receive_status_control bits
`define SBT_RX_PORT_EN 7
`define SBT_RX_SINGLE 5
`define SBT_RX_CONT 4

// baud_control bits
`define SBT_BAUD_IDLE 6
`define SBT_BAUD_POL 4
`define SBT_BAUD_WIDE 3
`define SBT_BAUD_WAKE 1
`define SBT_BAUD_ABD 0

// Flag register bits
`define SBT_FLAG_TXBE 0
`define SBT_FLAG_TXIE 1
`define SBT_FLAG_RXRDY 2

// Reset values
`define SBT_TX_CTRL_RST 8'h02
`define SBT_RX_CTRL_RST 8'h00
`define SBT_BAUD_CTRL_RST 8'h00

// Break frame: twelve zero bits after the start bit
`define SBT_BREAK_ZEROS 12
`define SBT_BIT_CNT_W 4

`endif

// ---- logic/sbt_pin_sync.v ----
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the input comes from outside the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none

module sbt_pin_sync (
  input wire sys_clk,
  input wire reset_n,
  input wire pin_async,
  output reg pin_level
);

  reg stage1;
  reg stage2;
  reg stage3;

  // Stage one feeds only stage two, so metastability cannot leak sideways
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      stage1 <= pin_async;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        pin_level <= stage2;
      end
    end
  end

endmodule // sbt_pin_sync

`default_nettype wire

// ---- logic/sbt_transmitter.v ----
// Break and synchronous master transmitter with its register file.
// Assumes a plain register port on sys_clk and pins seen through a transceiver.
//
// Overview of operation
// RQ1 - Break frame is a start bit, twelve zero bits, then a stop bit.
// RQ2 - Send-break plus enable with a load sends break, ignoring written data.
// RQ3 - Hardware clears send-break after the break stop bit is out.
// RQ4 - Host sets break, writes dummy then 55h; sync byte follows the break.
// RQ5 - Shift-register-empty shows active or idle during break frames too.
// RQ6 - Host may receive break by running baud at nine thirteenths.
// RQ7 - Auto-wake watches two receive transitions, flagging the receive event.
// RQ8 - Host enables auto-baud after seeing buffer-empty following a break.
// RQ9 - Wake sequence needs no instruction clocks; port idles while wake set.
// RQ10 - Master, sync and port-enable bits select mode and turn pins to clock/data.
// RQ11 - Synchronous master transfers are half-duplex.
// RQ12 - Master drives shift clock; polarity bit picks idle high or low.
// RQ13 - Shift register reloads only after last bit, then takes waiting byte.
// RQ14 - Buffer-to-shifter move takes one cycle, then buffer-empty flag sets.
// RQ15 - Buffer-empty flag is set regardless of enable; only a buffer write clears it.
// RQ16 - Interrupt enable gates the request, not the flag.
// RQ17 - Shift-register-empty is read-only, set when empty, polled only.
// RQ18 - Shift register has no software address; only the buffer is writable.
// RQ19 - Host programs divider, mode bits, enable, ninth bit, then data.
// RQ20 - Wake enable idles the receiver; a falling receive edge flags wake.
// RQ21 - Synchronous words shift LSB first, one bit per shift clock period.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_defs.vh"

module sbt_transmitter #(
  parameter DIV_W = 16
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire receive_pin,
  output reg transmit_pin,
  output reg transmit_pin_oe_n,
  output reg shift_clock_pin,
  output reg shift_clock_pin_oe_n,
  output reg irq_request,
  output reg receive_ready_flag
);

  localparam ST_IDLE = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_SHIFT = 2'h2;

  reg [7:0] receive_status_control;
  reg [7:0] transmit_status_control;
  reg [7:0] baud_control;
  reg [7:0] baud_divider_high;
  reg [7:0] baud_divider_low;
  reg [7:0] transmit_holding_buffer;
  reg tx_buffer_empty_flag;
  reg tx_buffer_empty_irq_en;
  reg [12:0] transmit_shift_register;
  reg [`SBT_BIT_CNT_W-1:0] bits_left;
  reg [1:0] state;
  reg [DIV_W-1:0] div_count;
  reg half_phase;
  reg break_frame;
  reg rx_prev;
  reg [1:0] wake_edges;
  wire rx_level;

  wire port_enable = receive_status_control[`SBT_RX_PORT_EN];
  wire transmit_enable_bit = transmit_status_control[`SBT_TX_ENABLE];
  wire sync_mode = transmit_status_control[`SBT_TX_SYNC];
  wire clock_source_master_select = transmit_status_control[`SBT_TX_MASTER];
  wire send_break_request = transmit_status_control[`SBT_TX_BREAK];
  wire ninth_bit_tx_enable = transmit_status_control[`SBT_TX_NINTH_EN];
  wire ninth_tx_bit_value = transmit_status_control[`SBT_TX_NINTH_VAL];
  wire clock_idle_polarity = baud_control[`SBT_BAUD_POL];
  wire divider_width_select = baud_control[`SBT_BAUD_WIDE];
  wire wake_on_edge_enable = baud_control[`SBT_BAUD_WAKE];
  wire sync_master = sync_mode & clock_source_master_select & port_enable; // RQ10
  // Receive enables hold off transmission in synchronous master mode
  wire rx_active = sync_mode & (receive_status_control[`SBT_RX_SINGLE] |
    receive_status_control[`SBT_RX_CONT]); // RQ11
  wire shift_reg_empty = (state != ST_SHIFT); // RQ17
  wire [DIV_W-1:0] div_reload = divider_width_select ?
    {baud_divider_high, baud_divider_low} : {{(DIV_W-8){1'b0}}, baud_divider_low};
  wire bit_tick = (div_count == {DIV_W{1'b0}});
  wire buf_write = reg_write && (reg_addr == `SBT_ADDR_TX_BUF);
  // Start bit plus the zero bits; only the low counter bits are used
  wire [31:0] break_count = `SBT_BREAK_ZEROS + 1;

  sbt_pin_sync u_rx_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin_async(receive_pin),
    .pin_level(rx_level)
  );

  // Register writes; the shift register is deliberately not decoded
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      receive_status_control <= `SBT_RX_CTRL_RST;
      transmit_status_control <= `SBT_TX_CTRL_RST;
      baud_control <= `SBT_BAUD_CTRL_RST;
      baud_divider_high <= 8'h00;
      baud_divider_low <= 8'h00;
      transmit_holding_buffer <= 8'h00;
      tx_buffer_empty_irq_en <= 1'b0;
    end else begin
      if (reg_write) begin
        case (reg_addr)
          `SBT_ADDR_RX_CTRL: receive_status_control <= reg_wdata;
          `SBT_ADDR_TX_BUF: transmit_holding_buffer <= reg_wdata; // RQ18
          `SBT_ADDR_BAUD_CTRL: begin
            baud_control[`SBT_BAUD_POL] <= reg_wdata[`SBT_BAUD_POL];
            baud_control[`SBT_BAUD_WIDE] <= reg_wdata[`SBT_BAUD_WIDE];
            baud_control[`SBT_BAUD_ABD] <= reg_wdata[`SBT_BAUD_ABD];
          end
          `SBT_ADDR_DIV_HIGH: baud_divider_high <= reg_wdata;
          `SBT_ADDR_DIV_LOW: baud_divider_low <= reg_wdata;
          `SBT_ADDR_FLAGS: tx_buffer_empty_irq_en <= reg_wdata[`SBT_FLAG_TXIE];
          default: ;
        endcase
      end
      // Status bit is a live copy; software cannot write it
      transmit_status_control[`SBT_TX_SR_EMPTY] <= shift_reg_empty; // RQ17 RQ5
      baud_control[`SBT_BAUD_IDLE] <= ~wake_on_edge_enable;
      // Wake bit: software sets it, a rising edge after the wake event clears it
      if (wake_on_edge_enable && wake_edges == 2'h1 && rx_level && !rx_prev) begin
        baud_control[`SBT_BAUD_WAKE] <= 1'b0; // RQ7 RQ9
      end else if (reg_write && reg_addr == `SBT_ADDR_BAUD_CTRL) begin
        baud_control[`SBT_BAUD_WAKE] <= reg_wdata[`SBT_BAUD_WAKE];
      end
      if (reg_write && reg_addr == `SBT_ADDR_TX_CTRL) begin
        transmit_status_control[7:2] <= reg_wdata[7:2];
        transmit_status_control[0] <= reg_wdata[0];
      end
      // Hardware clear of the break request wins over a same-cycle write
      if (state == ST_SHIFT && break_frame && bits_left == 4'h0 && bit_tick) begin
        transmit_status_control[`SBT_TX_BREAK] <= 1'b0; // RQ3 RQ4
      end
    end
  end

  // Transmit engine
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      tx_buffer_empty_flag <= 1'b1;
      transmit_shift_register <= 13'h1FFF;
      bits_left <= 4'h0;
      div_count <= {DIV_W{1'b0}};
      half_phase <= 1'b0;
      break_frame <= 1'b0;
    end else begin
      // The set from the load below is later in the block, so it wins
      if (buf_write) begin
        tx_buffer_empty_flag <= 1'b0; // RQ15
      end
      case (state)
        ST_IDLE: begin
          half_phase <= 1'b0;
          div_count <= div_reload;
          if (!tx_buffer_empty_flag && transmit_enable_bit && !wake_on_edge_enable &&
              !(sync_master && rx_active)) begin // RQ9 RQ11 RQ13
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // One cycle move from holding buffer into the shifter
          tx_buffer_empty_flag <= 1'b1; // RQ14 RQ15
          state <= ST_SHIFT;
          if (sync_master) begin
            break_frame <= 1'b0;
            transmit_shift_register <= {4'hF, ninth_tx_bit_value,
              transmit_holding_buffer}; // RQ21
            bits_left <= ninth_bit_tx_enable ? 4'h8 : 4'h7;
          end else if (send_break_request) begin
            break_frame <= 1'b1;
            // Written value ignored: start plus twelve zeros, then stop
            transmit_shift_register <= 13'h0000; // RQ1 RQ2
            bits_left <= break_count[`SBT_BIT_CNT_W-1:0];
          end else begin
            break_frame <= 1'b0;
            transmit_shift_register <= {3'h7, ninth_bit_tx_enable ? ninth_tx_bit_value : 1'b1,
              transmit_holding_buffer, 1'b0};
            bits_left <= ninth_bit_tx_enable ? 4'hA : 4'h9;
          end
        end
        ST_SHIFT: begin
          if (bit_tick) begin
            div_count <= div_reload;
            // In synchronous master mode a bit spans both clock half periods
            if (sync_master && !half_phase) begin
              half_phase <= 1'b1;
            end else begin
              half_phase <= 1'b0;
              transmit_shift_register <= {1'b1, transmit_shift_register[12:1]}; // RQ21
              if (bits_left == 4'h0) begin
                state <= ST_IDLE; // RQ13
              end else begin
                bits_left <= bits_left - 4'h1;
              end
            end
          end else begin
            div_count <= div_count - {{(DIV_W-1){1'b0}}, 1'b1};
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Auto-wake edge watcher on the receive line
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      rx_prev <= 1'b1;
      wake_edges <= 2'h0;
      receive_ready_flag <= 1'b0;
    end else begin
      rx_prev <= rx_level;
      if (wake_on_edge_enable && rx_prev != rx_level && wake_edges != 2'h2) begin
        wake_edges <= wake_edges + 2'h1; // RQ7
      end else if (!wake_on_edge_enable) begin
        wake_edges <= 2'h0;
      end
      // Raised on the falling wake edge; a read of the flags register clears it
      if (wake_on_edge_enable && wake_edges == 2'h0 && rx_prev && !rx_level) begin
        receive_ready_flag <= 1'b1; // RQ20
      end else if (reg_read && reg_addr == `SBT_ADDR_FLAGS) begin
        receive_ready_flag <= 1'b0;
      end
    end
  end

  // Pins, interrupt request and read data
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      transmit_pin <= 1'b1;
      transmit_pin_oe_n <= 1'b1;
      shift_clock_pin <= 1'b0;
      shift_clock_pin_oe_n <= 1'b1;
      irq_request <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      transmit_pin <= (state == ST_SHIFT) ? transmit_shift_register[0] : 1'b1;
      transmit_pin_oe_n <= ~port_enable;
      // Clock toggles off idle in the first half of each bit
      shift_clock_pin <= clock_idle_polarity ^
        (sync_master && state == ST_SHIFT && !half_phase); // RQ12
      shift_clock_pin_oe_n <= ~sync_master; // RQ10 RQ12
      irq_request <= tx_buffer_empty_flag & tx_buffer_empty_irq_en; // RQ16
      reg_rdata <= 8'h00;
      if (reg_read) begin
        case (reg_addr)
          `SBT_ADDR_RX_CTRL: reg_rdata <= receive_status_control;
          `SBT_ADDR_TX_BUF: reg_rdata <= transmit_holding_buffer;
          `SBT_ADDR_TX_CTRL: reg_rdata <= transmit_status_control;
          `SBT_ADDR_BAUD_CTRL: reg_rdata <= baud_control;
          `SBT_ADDR_DIV_HIGH: reg_rdata <= baud_divider_high;
          `SBT_ADDR_DIV_LOW: reg_rdata <= baud_divider_low;
          `SBT_ADDR_FLAGS: reg_rdata <= {5'h00, receive_ready_flag,
            tx_buffer_empty_irq_en, tx_buffer_empty_flag};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // sbt_transmitter

`default_nettype wire

// ---- tb/sbt_transmitter_properties.sv ----
// Port checker for the break and sync master transmitter.
// Assumes binding onto sbt_transmitter; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sbt_transmitter_properties (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic receive_pin,
  input wire logic transmit_pin,
  input wire logic transmit_pin_oe_n,
  input wire logic shift_clock_pin,
  input wire logic shift_clock_pin_oe_n,
  input wire logic irq_request,
  input wire logic receive_ready_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_unmapped_zero: assert property (
    reg_read && reg_addr == 3'h7 |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_rx_flag_hold: assert property (
    receive_ready_flag && !(reg_read && reg_addr == 3'h6) |=> receive_ready_flag)
    else $error("receive flag lost");
  a_rx_flag_clear: assert property (
    reg_read && reg_addr == 3'h6 |=> !receive_ready_flag) else $error("flag not cleared");
  a_wake_needs_low: assert property (
    $rose(receive_ready_flag) |-> !$past(receive_pin, 2)) else $error("wake without edge");
  a_tx_idle_high: assert property (
    transmit_pin_oe_n |-> transmit_pin) else $error("undriven line not high");
  a_clk_needs_port: assert property (
    !shift_clock_pin_oe_n |-> !transmit_pin_oe_n) else $error("clock without port");
  a_port_drives: assert property (
    reg_write && reg_addr == 3'h0 && reg_wdata[7] |-> ##[1:2] !transmit_pin_oe_n)
    else $error("port not driven");
  a_irq_gate_off: assert property (
    reg_write && reg_addr == 3'h6 && !reg_wdata[1] |-> ##[1:2] !irq_request)
    else $error("irq not gated");
  c_wake: cover property ($rose(receive_ready_flag));
  c_sync_clk: cover property (!shift_clock_pin_oe_n && $changed(shift_clock_pin));
  c_irq: cover property ($rose(irq_request));
endmodule // sbt_transmitter_properties
bind sbt_transmitter sbt_transmitter_properties i_sbt_transmitter_properties (.*);
`default_nettype wire

// ---- tb/sbt_peer_model.sv ----
// Far side: serial peer and sync slave sampling the transmit pins.
// Assumes pins sampled on sys_clk; receive line paced by an 80 ns clock.
`timescale 1ns/1ps
`default_nettype none
module sbt_peer_model (
  input wire logic sys_clk,
  input wire logic transmit_pin,
  input wire logic shift_clock_pin,
  output logic receive_pin
);
  logic link_clk = 1'b0;
  initial receive_pin = 1'b1;
  initial begin
    #3;
    forever #40 link_clk = ~link_clk;
  end
  // Line idles high, so a drop is a wake event
  task automatic drive_rx(input logic v);
    @(posedge link_clk);
    receive_pin <= v;
  endtask
  // A wait that runs out counts as a mismatch and ends the run
  task automatic report_hang();
    test_sbt_transmitter.bad_count++;
    test_sbt_transmitter.give_verdict();
  endtask
  // No wait after the last bit, so a frame right behind is not missed
  task automatic get_async(input int cyc, input int n, output logic [15:0] bits);
    int i;
    bits = 'x;
    for (i = 0; i < 4000 && transmit_pin !== 1'b0; i++) @(posedge sys_clk);
    if (i == 4000) report_hang();
    repeat (cyc / 2) @(posedge sys_clk);
    for (i = 0; i < n; i++) begin
      bits[i] = transmit_pin;
      if (i < n - 1) repeat (cyc) @(posedge sys_clk);
    end
  endtask
  // Sample as the clock returns to idle, half a period after data moves
  task automatic get_sync(input logic pol, output logic [7:0] d);
    int i;
    for (int k = 0; k < 8; k++) begin
      for (i = 0; i < 4000 && shift_clock_pin === pol; i++) @(posedge sys_clk);
      if (i == 4000) report_hang();
      for (i = 0; i < 4000 && shift_clock_pin !== pol; i++) @(posedge sys_clk);
      if (i == 4000) report_hang();
      d[k] = transmit_pin;
    end
  endtask
endmodule // sbt_peer_model
`default_nettype wire

// ---- tb/test_sbt_transmitter.sv ----
// Self-checking bench for the break and sync master transmitter.
// Assumes the checker is bound in and the peer model sits on the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_sbt_transmitter;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata, q, a, b, g1, g2;
  logic [15:0] bits, bits2;
  logic receive_pin, transmit_pin, transmit_pin_oe_n, shift_clock_pin, shift_clock_pin_oe_n;
  logic irq_request, receive_ready_flag;
  int bad_count = 0;
  int cmp_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  sbt_transmitter i_sbt_transmitter (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .receive_pin(receive_pin),
    .transmit_pin(transmit_pin),
    .transmit_pin_oe_n(transmit_pin_oe_n),
    .shift_clock_pin(shift_clock_pin),
    .shift_clock_pin_oe_n(shift_clock_pin_oe_n),
    .irq_request(irq_request),
    .receive_ready_flag(receive_ready_flag)
  );
  sbt_peer_model i_sbt_peer_model (.sys_clk(sys_clk), .transmit_pin(transmit_pin),
    .shift_clock_pin(shift_clock_pin), .receive_pin(receive_pin));
  function automatic logic [9:0] frame_of(input logic [7:0] d);
    return {1'b1, d, 1'b0};
  endfunction
  // Tasks end one idle edge after the strobe, so calls never overlap
  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] ad, output logic [7:0] v);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic poll(input logic [2:0] ad, input int bt, input logic val);
    logic [7:0] v;
    for (int i = 0; i < 300; i++) begin
      rd(ad, v);
      if (v[bt] === val) return;
    end
    bad_count++;
    give_verdict();
  endtask
  initial begin
    void'($urandom(36574));
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    wr(3'h2, 8'h00);
    rd(3'h2, q);
    `CHK(q, 8'h02)
    rd(3'h3, q);
    `CHK(q, 8'h40)
    wr(3'h7, 8'hFF);
    rd(3'h7, q);
    `CHK(q, 8'h00)
    wr(3'h6, 8'h02);
    rd(3'h6, q);
    `CHK(q, 8'h03)
    `CHK(irq_request, 1'b1)
    wr(3'h6, 8'h00);
    @(posedge sys_clk);
    `CHK(irq_request, 1'b0)
    wr(3'h5, 8'h08);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'h80);
    wr(3'h2, 8'h28);
    a = 8'($urandom);
    fork
      begin
        // Second listener runs at nine thirteenths of the bit rate
        fork
          i_sbt_peer_model.get_async(9, 14, bits);
          i_sbt_peer_model.get_async(13, 10, bits2);
        join
        `CHK(bits[13:0], 14'h2000)
        `CHK(bits2[9:0], frame_of(8'h00))
        i_sbt_peer_model.get_async(9, 10, bits);
        `CHK(bits[9:0], frame_of(8'h55))
      end
      begin
        wr(3'h1, a);
        // Buffer is one deep: wait until the dummy has moved on
        poll(3'h6, 0, 1'b1);
        wr(3'h1, 8'h55);
        repeat (8) @(posedge sys_clk);
        rd(3'h2, q);
        `CHK(q[3:1], 3'b100)
      end
    join
    poll(3'h2, 1, 1'b1);
    rd(3'h2, q);
    `CHK(q[3], 1'b0)
    rd(3'h6, q);
    `CHK(q[0], 1'b1)
    // Wide divider and ninth bit: 265 cycles a bit, ninth bit low
    wr(3'h3, 8'h08);
    wr(3'h4, 8'h01);
    wr(3'h2, 8'h60);
    a = 8'($urandom);
    fork
      i_sbt_peer_model.get_async(265, 11, bits);
      wr(3'h1, a);
    join
    `CHK(bits[10:0], {2'b10, a, 1'b0})
    poll(3'h2, 1, 1'b1);
    wr(3'h3, 8'h01);
    for (int p = 0; p < 2; p++) begin
      wr(3'h2, 8'h00);
      wr(3'h3, {3'b000, p[0], 4'h0});
      wr(3'h2, 8'hB0);
      @(posedge sys_clk);
      `CHK(shift_clock_pin, p[0])
      `CHK(shift_clock_pin_oe_n, 1'b0)
      `CHK(transmit_pin_oe_n, 1'b0)
      a = 8'($urandom);
      b = p ? 8'h80 : 8'($urandom);
      fork
        begin
          i_sbt_peer_model.get_sync(p[0], g1);
          i_sbt_peer_model.get_sync(p[0], g2);
        end
        begin
          wr(3'h1, a);
          poll(3'h6, 0, 1'b1);
          wr(3'h1, b);
          rd(3'h6, q);
          `CHK(q[0], 1'b0)
        end
      join
      `CHK(g1, a)
      `CHK(g2, b)
      poll(3'h2, 1, 1'b1);
    end
    wr(3'h0, 8'hA0);
    a = 8'($urandom);
    wr(3'h1, a);
    repeat (40) begin
      @(posedge sys_clk);
      `CHK(shift_clock_pin, 1'b1)
    end
    fork
      i_sbt_peer_model.get_sync(1'b1, g1);
      wr(3'h0, 8'h80);
    join
    `CHK(g1, a)
    wr(3'h2, 8'h20);
    wr(3'h3, 8'h02);
    // A queued byte must wait while the wake monitor is armed
    wr(3'h1, a);
    i_sbt_peer_model.drive_rx(1'b0);
    repeat (20) @(posedge sys_clk);
    `CHK(receive_ready_flag, 1'b1)
    `CHK(transmit_pin, 1'b1)
    i_sbt_peer_model.drive_rx(1'b1);
    repeat (20) @(posedge sys_clk);
    rd(3'h3, q);
    `CHK(q[1], 1'b0)
    rd(3'h6, q);
    `CHK(q[2], 1'b1)
    `CHK(receive_ready_flag, 1'b0)
    give_verdict();
  end
endmodule // test_sbt_transmitter
`default_nettype wire
